// File: design/rtch_pkg.sv
// constants, encodings and states of the rf tag command handler
package rtch_pkg;
    // command codes
    localparam logic [7:0] CMD_READ_MULTI = 8'h23;
    localparam logic [7:0] CMD_SELECT = 8'h25;
    localparam logic [7:0] CMD_RESET_READY = 8'h26;
    localparam logic [7:0] CMD_WRITE_AFI = 8'h27;
    // error codes and response flag bytes
    localparam logic [7:0] ERR_OPTION = 8'h03;
    localparam logic [7:0] ERR_GENERIC = 8'h0f;
    localparam logic [7:0] ERR_NO_BLOCK = 8'h10;
    localparam logic [7:0] ERR_LOCKED = 8'h12;
    localparam logic [7:0] ERR_PROG_FAIL = 8'h13;
    localparam logic [7:0] ERR_READ_PROT = 8'h15;
    localparam logic [7:0] RSP_FLAGS_OK = 8'h00;
    localparam logic [7:0] RSP_FLAGS_ERR = 8'h01;
    // request flag bit positions
    localparam int FLAG_PROT_EXT = 3;
    localparam int FLAG_SELECT = 4;
    localparam int FLAG_ADDRESS = 5;
    localparam int FLAG_OPTION = 6;
    localparam int FLAG_RFU = 7;
    // memory geometry
    localparam int BLK_W = 16;
    localparam int SEC_STAT_W = 5;
    localparam int NUM_BLOCKS_DEF = 512;
    localparam int SECTOR_BLOCKS_DEF = 32;
    // programming time: nominal response delay plus 18 periods of 302 us
    localparam int CLK_PERIOD_NS = 50;
    localparam int NOM_RESP_DELAY_NS = 50;
    localparam int PROG_PERIOD_US = 302;
    localparam int PROG_PERIODS = 18;
    localparam int PROG_NS = NOM_RESP_DELAY_NS
        + PROG_PERIODS * PROG_PERIOD_US * 1000;
    localparam int PROG_CYCLES_DEF = (PROG_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // register map, byte addresses on the wishbone bus
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_UID_LO = 8'h04;
    localparam logic [7:0] REG_UID_HI = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam int CTRL_BUSY_MODE_BIT = 0;
    localparam logic CTRL_BUSY_MODE_RESET = 1'b0;
    // arbitrary neutral identifier value
    localparam logic [63:0] UID_INIT_DEF = 64'h0000_0000_0000_0001;
    // handler states, gray along idle-exec-fetch-send-wait
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_EXEC = 3'b001,
        S_FETCH = 3'b011,
        S_SEND = 3'b010,
        S_WAIT = 3'b110,
        S_PROG = 3'b111
    } rtch_state_t;
endpackage

// File: design/rtch_cmd_handler.sv
// rf-side command handler: read multiple, select, reset to ready, write afi
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module rtch_cmd_handler #(
    parameter int NUM_BLOCKS = rtch_pkg::NUM_BLOCKS_DEF,
    parameter int SECTOR_BLOCKS = rtch_pkg::SECTOR_BLOCKS_DEF,
    parameter int PROG_CYCLES = rtch_pkg::PROG_CYCLES_DEF,
    parameter logic [63:0] UID_INIT = rtch_pkg::UID_INIT_DEF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // decoded request from the frame layer
    input wire logic req_sof_i,
    input wire logic req_valid_i,
    input wire logic req_abort_i,
    input wire logic [7:0] req_flags_i,
    input wire logic [7:0] req_cmd_i,
    input wire logic [63:0] req_uid_i,
    input wire logic [rtch_pkg::BLK_W-1:0] req_block_i,
    input wire logic [7:0] req_count_i,
    input wire logic [7:0] req_afi_i,
    // response byte stream to the frame layer
    output logic rsp_valid_o,
    output logic [7:0] rsp_byte_o,
    output logic rsp_last_o,
    input wire logic rsp_ready_i,
    input wire logic rsp_done_i,
    // block memory read port
    output logic mem_rd_o,
    output logic [rtch_pkg::BLK_W-1:0] mem_addr_o,
    input wire logic mem_rvalid_i,
    input wire logic [31:0] mem_rdata_i,
    input wire logic [rtch_pkg::SEC_STAT_W-1:0] mem_sec_i,
    input wire logic mem_rdprot_i,
    // nonvolatile family identifier write
    output logic nvm_wr_o,
    output logic [7:0] nvm_data_o,
    input wire logic afi_locked_i,
    input wire logic nvm_done_i,
    input wire logic nvm_ok_i,
    // activity pin and tag state
    output logic rf_activity_pin_o,
    output logic rf_activity_pin_oe_o,
    output logic selected_o
);
    import rtch_pkg::*;

    localparam int TMR_W = $clog2(PROG_CYCLES + 1);
    localparam int SEC_SH = $clog2(SECTOR_BLOCKS);

    typedef struct packed {
        rtch_state_t state;
        logic selected;
        logic busy_mode;
        logic [63:0] uid;
        logic [7:0] flags;
        logic [7:0] cmd;
        logic [63:0] ruid;
        logic [BLK_W-1:0] blk;
        logic [7:0] cnt;
        logic [7:0] afi;
        logic first;
        logic [47:0] obuf;
        logic [2:0] ocnt;
        logic ovld;
        logic olast;
        logic final_chunk;
        logic mem_rd;
        logic nvm_wr;
        logic nvm_done;
        logic nvm_ok;
        logic [TMR_W-1:0] timer;
        logic act_oe;
        logic [7:0] last_err;
        logic wb_ack;
        logic [31:0] wb_dat;
    } rtch_regs_t;

    rtch_regs_t st;
    rtch_regs_t next_st;

    // request qualifiers, all from flops: captured fields, the uid register and the selected state
    logic uid_ok;
    logic skip;
    logic [BLK_W:0] last_blk;
    logic range_bad;
    logic crosses;
    assign uid_ok = st.ruid == st.uid;
    assign skip = (st.flags[FLAG_ADDRESS] && !uid_ok)
        || (st.flags[FLAG_SELECT] && !st.selected);
    assign last_blk = {1'b0, st.blk} + {{(BLK_W + 1 - 8){1'b0}}, st.cnt};
    assign range_bad = last_blk >= (BLK_W + 1)'(NUM_BLOCKS);
    // same sector means same upper block bits at both ends
    assign crosses = (last_blk >> SEC_SH) != ({1'b0, st.blk} >> SEC_SH);

    // outputs are flops, plain slices of flops or a constant
    assign wb_dat_o = st.wb_dat;
    assign wb_ack_o = st.wb_ack;
    assign rsp_valid_o = st.ovld;
    assign rsp_byte_o = st.obuf[7:0];
    assign rsp_last_o = st.olast;
    assign mem_rd_o = st.mem_rd;
    assign mem_addr_o = st.blk;
    assign nvm_wr_o = st.nvm_wr;
    assign nvm_data_o = st.afi;
    assign rf_activity_pin_o = 1'b0; // pin is only ever pulled low
    assign rf_activity_pin_oe_o = st.act_oe;
    assign selected_o = st.selected;

    // next-state logic for bus, handler and pin
    always_comb begin
        logic ld;
        logic ld_final;
        logic [47:0] ld_buf;
        logic [2:0] ld_cnt;
        logic [39:0] body;
        logic [2:0] bcnt;
        ld = 1'b0;
        ld_final = 1'b0;
        ld_buf = 48'h0;
        ld_cnt = 3'd0;
        body = 40'h0;
        bcnt = 3'd0;
        next_st = st;
        next_st.mem_rd = 1'b0;
        next_st.nvm_wr = 1'b0;

        // wishbone: ack one cycle after the strobe, write at the ack edge
        next_st.wb_ack = wb_cyc_i && wb_stb_i && !st.wb_ack;
        next_st.wb_dat = 32'h0;
        if (wb_cyc_i && wb_stb_i && !st.wb_ack && !wb_we_i) begin
            case (wb_adr_i)
                REG_CTRL: next_st.wb_dat = {31'h0, st.busy_mode};
                REG_UID_LO: next_st.wb_dat = st.uid[31:0];
                REG_UID_HI: next_st.wb_dat = st.uid[63:32];
                REG_STATUS: next_st.wb_dat = {16'h0, st.last_err, 3'b000,
                    st.state, st.selected, st.act_oe};
                default: next_st.wb_dat = 32'h0;
            endcase
        end
        if (wb_cyc_i && wb_stb_i && wb_we_i && st.wb_ack) begin
            for (int i = 0; i < 4; i++) begin
                if (wb_sel_i[i]) begin
                    case (wb_adr_i)
                        REG_UID_LO: next_st.uid[i*8 +: 8] = wb_dat_i[i*8 +: 8];
                        REG_UID_HI: next_st.uid[32+i*8 +: 8] =
                            wb_dat_i[i*8 +: 8];
                        default: ;
                    endcase
                end
            end
            if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
                next_st.busy_mode = wb_dat_i[CTRL_BUSY_MODE_BIT];
            end
        end

        // response shifter, one byte per accepted handshake
        if (st.ovld && rsp_ready_i) begin
            next_st.obuf = st.obuf >> 8;
            next_st.ocnt = st.ocnt - 3'd1;
            next_st.ovld = st.ocnt != 3'd1;
            next_st.olast = st.final_chunk && st.ocnt == 3'd2;
        end

        // program completion is sticky so a done pulse is never missed
        if (nvm_done_i) begin
            next_st.nvm_done = 1'b1;
            next_st.nvm_ok = nvm_ok_i;
        end
        if (st.timer != '0) begin
            next_st.timer = st.timer - 1'b1;
        end

        // command sequencing
        case (st.state)
            S_IDLE: begin
                if (req_valid_i) begin
                    next_st.flags = req_flags_i;
                    next_st.cmd = req_cmd_i;
                    next_st.ruid = req_uid_i;
                    next_st.blk = req_block_i;
                    next_st.cnt = req_count_i;
                    next_st.afi = req_afi_i;
                    next_st.state = S_EXEC;
                end
            end
            S_EXEC: begin
                next_st.state = S_IDLE;
                case (st.cmd)
                    CMD_SELECT: begin
                        if (!uid_ok) begin
                            next_st.selected = 1'b0;
                        end else if (st.flags[FLAG_RFU]) begin
                            ld = 1'b1;
                            ld_buf = {32'h0, ERR_OPTION, RSP_FLAGS_ERR};
                        end else begin
                            next_st.selected = 1'b1;
                            ld = 1'b1;
                            ld_buf = {40'h0, RSP_FLAGS_OK};
                        end
                    end
                    CMD_RESET_READY: begin
                        if (skip) begin
                            next_st.state = S_IDLE;
                        end else if (st.flags[FLAG_RFU]) begin
                            ld = 1'b1;
                            ld_buf = {32'h0, ERR_OPTION, RSP_FLAGS_ERR};
                        end else begin
                            next_st.selected = 1'b0;
                            ld = 1'b1;
                            ld_buf = {40'h0, RSP_FLAGS_OK};
                        end
                    end
                    CMD_READ_MULTI: begin
                        if (skip) begin
                            next_st.state = S_IDLE;
                        end else if (!st.flags[FLAG_PROT_EXT]) begin
                            ld = 1'b1;
                            ld_buf = {32'h0, ERR_GENERIC, RSP_FLAGS_ERR};
                        end else if (range_bad) begin
                            ld = 1'b1;
                            ld_buf = {32'h0, ERR_NO_BLOCK, RSP_FLAGS_ERR};
                        end else if (crosses) begin
                            ld = 1'b1;
                            ld_buf = {32'h0, ERR_GENERIC, RSP_FLAGS_ERR};
                        end else begin
                            // field holds blocks minus one
                            next_st.cnt = st.cnt + 8'h01;
                            next_st.first = 1'b1;
                            next_st.mem_rd = 1'b1;
                            next_st.state = S_FETCH;
                        end
                    end
                    CMD_WRITE_AFI: begin
                        if (skip) begin
                            next_st.state = S_IDLE;
                        end else if (afi_locked_i) begin
                            ld = 1'b1;
                            ld_buf = {32'h0, ERR_LOCKED, RSP_FLAGS_ERR};
                        end else begin
                            next_st.nvm_wr = 1'b1;
                            next_st.nvm_done = nvm_done_i;
                            next_st.timer = TMR_W'(PROG_CYCLES);
                            next_st.state = S_PROG;
                        end
                    end
                    default: next_st.state = S_IDLE;
                endcase
                ld_cnt = (ld_buf[7:0] == RSP_FLAGS_ERR) ? 3'd2 : 3'd1;
                ld_final = 1'b1;
            end
            S_FETCH: begin
                if (mem_rvalid_i) begin
                    if (st.first && mem_rdprot_i) begin
                        ld = 1'b1;
                        ld_buf = {32'h0, ERR_READ_PROT, RSP_FLAGS_ERR};
                        ld_cnt = 3'd2;
                        ld_final = 1'b1;
                    end else begin
                        // top three bits of the security byte stay zero
                        if (st.flags[FLAG_OPTION]) begin
                            body = {mem_rdata_i, 3'b000, mem_sec_i};
                            bcnt = 3'd5;
                        end else begin
                            body = {8'h0, mem_rdata_i};
                            bcnt = 3'd4;
                        end
                        ld = 1'b1;
                        ld_buf = st.first ? {body, RSP_FLAGS_OK}
                            : {8'h0, body};
                        ld_cnt = st.first ? bcnt + 3'd1 : bcnt;
                        ld_final = st.cnt == 8'h01;
                        next_st.cnt = st.cnt - 8'h01;
                        next_st.blk = st.blk + 16'h0001;
                        next_st.first = 1'b0;
                    end
                end
            end
            S_SEND: begin
                if (st.ovld && rsp_ready_i && st.ocnt == 3'd1) begin
                    if (st.final_chunk) begin
                        next_st.state = S_WAIT;
                    end else begin
                        next_st.mem_rd = 1'b1;
                        next_st.state = S_FETCH;
                    end
                end
            end
            S_WAIT: begin
                if (rsp_done_i) begin
                    next_st.state = S_IDLE;
                end
            end
            S_PROG: begin
                // reply waits for both the cell and the quiet time
                if (st.timer == '0 && st.nvm_done) begin
                    ld = 1'b1;
                    ld_buf = st.nvm_ok ? {40'h0, RSP_FLAGS_OK}
                        : {32'h0, ERR_PROG_FAIL, RSP_FLAGS_ERR};
                    ld_cnt = st.nvm_ok ? 3'd1 : 3'd2;
                    ld_final = 1'b1;
                end
            end
            default: next_st.state = S_IDLE;
        endcase

        if (ld) begin
            next_st.obuf = ld_buf;
            next_st.ocnt = ld_cnt;
            next_st.ovld = 1'b1;
            next_st.final_chunk = ld_final;
            next_st.olast = ld_final && ld_cnt == 3'd1;
            next_st.state = S_SEND;
            if (ld_buf[7:0] == RSP_FLAGS_ERR) begin
                next_st.last_err = ld_buf[15:8];
            end
        end

        // activity pin; silent endings release it as well
        if (next_st.busy_mode) begin
            if ((st.state != S_IDLE && next_st.state == S_IDLE)
                || (st.state == S_IDLE && req_abort_i)) begin
                next_st.act_oe = 1'b0;
            end else if (req_sof_i) begin
                next_st.act_oe = 1'b1;
            end
        end else begin
            // floats except while a family write is programming
            next_st.act_oe = next_st.state == S_PROG;
        end
    end

    // the whole state in one register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.uid <= UID_INIT;
            st.busy_mode <= CTRL_BUSY_MODE_RESET;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_count_plus_one: assert property (
        st.state == S_EXEC && st.cmd == CMD_READ_MULTI && !skip
        && st.flags[FLAG_PROT_EXT] && !range_bad && !crosses
        |=> st.state == S_FETCH && st.cnt == $past(st.cnt) + 8'h01)
        else $error("block count not taken as count plus one");
    a_fetch_bound: assert property (
        st.state == S_FETCH |-> st.cnt != 8'h00 && st.cnt <= 8'd32)
        else $error("more than 32 blocks in one read");
    a_cross_error: assert property (
        st.state == S_EXEC && st.cmd == CMD_READ_MULTI && !skip
        && st.flags[FLAG_PROT_EXT] && !range_bad && crosses
        |=> st.ovld && st.obuf[15:0] == {ERR_GENERIC, RSP_FLAGS_ERR})
        else $error("sector crossing not refused");
    a_ext_flag_err: assert property (
        st.state == S_EXEC && st.cmd == CMD_READ_MULTI && !skip
        && !st.flags[FLAG_PROT_EXT]
        |=> st.ovld && st.obuf[15:8] == ERR_GENERIC && !mem_rd_o)
        else $error("missing extension flag not refused");
    a_busy_sof: assert property (
        st.busy_mode && wb_ack_o == 1'b0 && req_sof_i && !req_abort_i
        && st.state == S_IDLE |=> rf_activity_pin_oe_o)
        else $error("busy pin not driven after start of frame");
    a_busy_hold: assert property (
        st.busy_mode && $stable(st.busy_mode) && st.state == S_WAIT
        && !rsp_done_i |=> rf_activity_pin_oe_o == $past(st.act_oe))
        else $error("busy pin released before end of response");
    a_wip_float: assert property (
        !st.busy_mode |-> rf_activity_pin_oe_o == (st.state == S_PROG))
        else $error("pin driven outside programming in wip mode");
    a_select_hit: assert property (
        st.state == S_EXEC && st.cmd == CMD_SELECT && uid_ok
        && !st.flags[FLAG_RFU]
        |=> selected_o && rsp_valid_o && rsp_byte_o == RSP_FLAGS_OK)
        else $error("matching select did not select and reply");
    a_select_miss: assert property (
        st.state == S_EXEC && st.cmd == CMD_SELECT && !uid_ok
        |=> !selected_o && !rsp_valid_o [*2])
        else $error("foreign select kept state or replied");
    a_err_keeps: assert property (
        st.state == S_EXEC && st.cmd == CMD_SELECT && uid_ok
        && st.flags[FLAG_RFU]
        |=> selected_o == $past(st.selected)
        && st.obuf[15:8] == ERR_OPTION)
        else $error("select error changed state or code");
    a_afi_start: assert property (
        st.state == S_EXEC && st.cmd == CMD_WRITE_AFI && !skip
        && !afi_locked_i |=> nvm_wr_o && nvm_data_o == $past(st.afi)
        ##1 !nvm_wr_o)
        else $error("family write not started as one pulse");
    a_afi_locked: assert property (
        st.state == S_EXEC && st.cmd == CMD_WRITE_AFI && !skip
        && afi_locked_i |=> !nvm_wr_o && st.obuf[15:8] == ERR_LOCKED)
        else $error("locked family write not refused");
    a_prog_wait: assert property (
        st.state == S_PROG && (st.timer != '0 || !st.nvm_done)
        |=> st.state == S_PROG && !rsp_valid_o)
        else $error("reply before program cycle finished");
endmodule
`default_nettype wire

// File: dv/rtch_far_model.sv
// far side model: block memory, nvm cell and response encoder
`timescale 1ns/1ns
`default_nettype none
module rtch_far_model (
    // clock
    input wire logic clk_i,
    // block memory
    input wire logic mem_rd_i,
    input wire logic [rtch_pkg::BLK_W-1:0] mem_addr_i,
    output logic mem_rvalid_o,
    output logic [31:0] mem_rdata_o,
    output logic [rtch_pkg::SEC_STAT_W-1:0] mem_sec_o,
    // nvm cell
    input wire logic nvm_wr_i,
    output logic nvm_done_o,
    // response encoder
    input wire logic rsp_valid_i,
    input wire logic rsp_last_i,
    output logic rsp_ready_o,
    output logic rsp_done_o
);
    logic [4:0] t;
    initial begin
        {mem_rvalid_o, mem_rdata_o, mem_sec_o, nvm_done_o, t} = '0;
        {rsp_ready_o, rsp_done_o} = '0;
    end
    // data lines flip when idle so no stale word looks valid
    always @(posedge clk_i) begin
        mem_rvalid_o <= mem_rd_i;
        mem_rdata_o <= mem_rd_i ? {16'ha5c3, mem_addr_i} : ~mem_rdata_o;
        mem_sec_o <= mem_addr_i[4:0];
        rsp_ready_o <= ~rsp_ready_o; // stalls every other cycle
        rsp_done_o <= rsp_valid_i && rsp_ready_o && rsp_last_i;
        t <= nvm_wr_i ? 5'd25 : (t != 0 ? t - 5'd1 : t);
        nvm_done_o <= t == 5'd1;
    end
endmodule
`default_nettype wire

// File: dv/rtch_cmd_handler_bench.sv
// self-checking bench of the rf tag command handler
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: value mismatch", $time); end end
module rtch_cmd_handler_bench;
    import rtch_pkg::*;
    typedef logic [7:0] rtch_bq_t [$];
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, req_flags_i, req_cmd_i, req_count_i, req_afi_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, mem_rdata_i, seed, rd;
    logic req_sof_i, req_valid_i, req_abort_i, rsp_valid_o, rsp_last_o;
    logic [63:0] req_uid_i;
    logic [15:0] req_block_i, mem_addr_o, b;
    logic [7:0] rsp_byte_o, nvm_data_o, n, afi_seen;
    logic rsp_ready_i, rsp_done_i, mem_rd_o, mem_rvalid_i, mem_rdprot_i;
    logic [4:0] mem_sec_i;
    logic nvm_wr_o, afi_locked_i, nvm_done_i, nvm_ok_i, selected_o;
    logic rf_activity_pin_o, rf_activity_pin_oe_o;
    logic [7:0] cm [2] = '{CMD_SELECT, CMD_RESET_READY};
    logic [15:0] eb [3] = '{16'd30, 16'd600, 16'd4};
    logic [7:0] ec [3] = '{ERR_GENERIC, ERR_NO_BLOCK, ERR_READ_PROT};
    rtch_bq_t got, exp;
    int failures = 0, comparisons = 0, cyc_n = 0, test_n = 0, t0, t1, t2;
    bit busy;
    rtch_cmd_handler #(.PROG_CYCLES(20)) i_dut (.clk_i, .rst_i, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .req_sof_i, .req_valid_i, .req_abort_i, .req_flags_i,
        .req_cmd_i, .req_uid_i, .req_block_i, .req_count_i, .req_afi_i,
        .rsp_valid_o, .rsp_byte_o, .rsp_last_o, .rsp_ready_i, .rsp_done_i,
        .mem_rd_o, .mem_addr_o, .mem_rvalid_i, .mem_rdata_i, .mem_sec_i,
        .mem_rdprot_i, .nvm_wr_o, .nvm_data_o, .afi_locked_i, .nvm_done_i,
        .nvm_ok_i, .rf_activity_pin_o, .rf_activity_pin_oe_o, .selected_o);
    rtch_far_model i_far (.clk_i(clk_i), .mem_rd_i(mem_rd_o),
        .mem_addr_i(mem_addr_o), .mem_rvalid_o(mem_rvalid_i),
        .mem_rdata_o(mem_rdata_i), .mem_sec_o(mem_sec_i), .nvm_wr_i(nvm_wr_o),
        .nvm_done_o(nvm_done_i), .rsp_valid_i(rsp_valid_o),
        .rsp_last_i(rsp_last_o), .rsp_ready_o(rsp_ready_i),
        .rsp_done_o(rsp_done_i));
    // 20 mhz clock
    initial begin
        clk_i = 0;
        forever #25 clk_i = ~clk_i;
    end
    // collect accepted reply bytes, catch programming starts
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (rsp_valid_o && rsp_ready_i) begin
            if (got.size() == 0) t1 = cyc_n;
            got.push_back(rsp_byte_o);
            `CHK(rf_activity_pin_oe_o, busy)
        end
        if (nvm_done_i) t2 = cyc_n;
        if (nvm_wr_o) begin
            afi_seen = nvm_data_o;
            `CHK(rf_activity_pin_oe_o, 1'b1)
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected read reply, data pattern as the far model returns it
    function automatic rtch_bq_t rd_exp(input logic [15:0] b,
        input logic [7:0] n, input bit opt);
        rtch_bq_t q;
        logic [31:0] d;
        q.push_back(RSP_FLAGS_OK);
        for (int k = 0; k <= n; k++) begin
            d = {16'ha5c3, b + 16'(k)};
            if (opt) q.push_back({3'b000, d[4:0]});
            for (int j = 0; j < 4; j++) q.push_back(d[8*j +: 8]);
        end
        return q;
    endfunction
    // classic single wishbone cycle, waits for ack however long
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <=
            {2'b11, we, 4'hf, a, d};
        do @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // one request frame, then wait for the reply to finish
    task automatic req(input logic [7:0] f, c, input logic [63:0] u,
        input logic [15:0] b, input logic [7:0] n, a, input bit quiet);
        got.delete();
        @(posedge clk_i);
        req_sof_i <= 1;
        @(posedge clk_i);
        req_sof_i <= 0;
        #1 `CHK({rf_activity_pin_o, rf_activity_pin_oe_o}, {1'b0, busy})
        @(posedge clk_i);
        {req_flags_i, req_cmd_i, req_uid_i, req_block_i, req_count_i,
            req_afi_i, req_valid_i} <= {f, c, u, b, n, a, 1'b1};
        t0 = cyc_n;
        @(posedge clk_i);
        req_valid_i <= 0;
        for (int i = 0; i < 900; i++) begin
            @(posedge clk_i);
            if (quiet ? i == 10 : rsp_done_i === 1'b1) break;
        end
        repeat (2) @(posedge clk_i);
    endtask
    task automatic chk_q();
        `CHK(got.size(), exp.size())
        foreach (exp[i]) `CHK(got[i], exp[i])
        `CHK(rf_activity_pin_oe_o, 1'b0)
        test_n++;
        $display("test %0d done", test_n);
    endtask
    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog, well past the longest expected run
    initial begin
        #2000000;
        failures++;
        finish_test();
    end
    // main sequence
    initial begin
        {rst_i, wb_sel_i, nvm_ok_i, seed} = {1'b1, 4'hf, 1'b1, 32'h6438};
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {req_sof_i, req_valid_i, req_abort_i, mem_rdprot_i, afi_locked_i} = '0;
        {req_flags_i, req_cmd_i, req_uid_i, req_block_i, req_count_i} = '0;
        req_afi_i = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        wb(0, 8'h40, 32'h5);
        `CHK(rd, 32'h0)
        wb(1, REG_CTRL, 32'h1);
        wb(0, REG_CTRL, 32'h0);
        `CHK(rd[0], 1'b1)
        busy = 1;
        exp = '{RSP_FLAGS_OK};
        req(8'h20, CMD_SELECT, UID_INIT_DEF, 0, 0, 0, 0);
        chk_q();
        `CHK(selected_o, 1'b1)
        exp.delete();
        req(8'h20, CMD_SELECT, ~UID_INIT_DEF, 0, 0, 0, 1);
        chk_q();
        `CHK(selected_o, 1'b0)
        foreach (cm[i]) begin
            exp = '{RSP_FLAGS_ERR, ERR_OPTION};
            req(8'ha0, cm[i], UID_INIT_DEF, 0, 0, 0, 0);
            chk_q();
        end
        `CHK(selected_o, 1'b0)
        req(8'h20, CMD_SELECT, UID_INIT_DEF, 0, 0, 0, 0);
        exp = '{RSP_FLAGS_OK};
        req(8'h20, CMD_RESET_READY, UID_INIT_DEF, 0, 0, 0, 0);
        chk_q();
        `CHK(selected_o, 1'b0)
        // dropped frame releases the pin at once
        @(posedge clk_i) req_sof_i <= 1;
        @(posedge clk_i) {req_sof_i, req_abort_i} <= 2'b01;
        @(posedge clk_i) req_abort_i <= 0;
        `CHK(rf_activity_pin_oe_o, 1'b1)
        @(posedge clk_i) `CHK(rf_activity_pin_oe_o, 1'b0)
        wb(1, REG_CTRL, 32'h0);
        busy = 0;
        // first pass is the full 32-block sector
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            b = i ? {7'b0, seed[8:0]} : 16'h0;
            n = i ? {3'b0, seed[20:16] & ~b[4:0]} : 8'd31;
            exp = rd_exp(b, n, seed[24]);
            req({1'b0, seed[24], 6'h08}, CMD_READ_MULTI, 0, b, n, 0, 0);
            chk_q();
        end
        foreach (eb[i]) begin
            exp = '{RSP_FLAGS_ERR, ec[i]};
            mem_rdprot_i <= i == 2;
            req(8'h08, CMD_READ_MULTI, 0, eb[i], 8'd2, 0, 0);
            chk_q();
        end
        exp = '{RSP_FLAGS_ERR, ERR_GENERIC};
        req(8'h00, CMD_READ_MULTI, 0, 0, 0, 0, 0);
        chk_q();
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            afi_locked_i <= i == 1;
            nvm_ok_i <= i != 2;
            exp = '{RSP_FLAGS_OK};
            if (i) exp = '{RSP_FLAGS_ERR, i == 1 ? ERR_LOCKED : ERR_PROG_FAIL};
            req(8'h40, CMD_WRITE_AFI, 0, 0, 0, seed[7:0], 0);
            chk_q();
            if (i == 0) `CHK(afi_seen, seed[7:0])
            if (i == 0) `CHK(t1 > t2 && t1 - t0 > 20, 1'b1)
        end
        finish_test();
    end
endmodule
`default_nettype wire
